// ### hdl/line_sense_status.sv
// line sense status register: sense code, live overload, dropout, protect
// assumes measurement inputs and controls are synchronous to clk_sys and a
// secondary-frame engine presents decoded read requests on sec_req
`timescale 1ns/1ns

// Notes on behaviour
// - five-bit sense code sits in bits 7:3
// - on-hook voltage 2.75 V per count, zero=no line
// - code 1 minimum voltage, 31 maximum voltage
// - loop current 3 mA per count, zero=too low
// - 1 min, 30 max normal, 31 overload
// - overload above 140 mA, 54 mA euro mode
// - bit 2 live overload, clears by itself
// - masked only by off-hook counter, not billing
// - off-hook supply collapse sets bit 1
// - dropout clears sixteen frames after recovery
// - dropout flag zero whenever on-hook
// - bit 0 shows overload protection active
// - read-only register, resets to all zeros
// - secondary read frame returns eight register bits
module line_sense_status
  import line_sense_pkg::*;
#(
  parameter int MA_W = 8,
  parameter int QV_W = 9
)
(
  input  wire logic             clk_sys,
  input  wire logic             arst_n,
  input  wire logic             frame_tick,
  input  wire ctrl_type         ctrl,
  input  wire logic             billing_tone_enable,
  input  wire logic [MA_W-1:0]  loop_current_ma,
  input  wire logic [QV_W-1:0]  line_voltage_qv,
  input  wire logic             rx_level_excess,
  input  wire logic             offhook_counter_run,
  input  wire logic             line_supply_ok,
  input  wire logic             protect_engaged,
  input  wire sec_req_type      sec_req,
  output logic                  rd_valid_q,
  output logic                  rd_hit_q,
  output logic [7:0]            rd_data_q,
  output status_type            status_q
);

  // ==========================================================
  // hook state
  // mode set together with an off-hook request is the forced on-hook
  // state, so the line is only truly off-hook with mode clear; dropout
  // and the loop current path both key off this one signal
  logic offhook;

  assign offhook = !ctrl.mode && ctrl.offhook_request;

  // ==========================================================
  // measurement conversion
  logic [MA_W-1:0] ovl_limit;
  logic [MA_W-1:0] ma_steps;
  logic [QV_W-1:0] qv_steps;
  logic [4:0]      current_code;
  logic [4:0]      voltage_code;
  logic [4:0]      monitor_code;
  src_type         src;
  logic [4:0]      code_d;

  // threshold picked per termination mode; the lower euro limit trips
  // well inside the normal scale, so codes 19 to 30 never show there
  always_comb
  begin
    if (ctrl.european_termination_mode)
    begin
      ovl_limit = MA_W'(OVL_MA_EURO);
    end
    else
    begin
      ovl_limit = MA_W'(OVL_MA_NORMAL);
    end
  end

  assign ma_steps = loop_current_ma / MA_W'(MA_PER_COUNT);
  assign qv_steps = line_voltage_qv / QV_W'(QV_PER_COUNT);

  // loop current code; normal range saturates one below the overload code
  always_comb
  begin
    if (loop_current_ma > ovl_limit)
      current_code = CODE_FULL;
    else if (ma_steps > MA_W'(CODE_MAX_NORMAL))
      current_code = CODE_MAX_NORMAL;
    else
      current_code = ma_steps[4:0];
  end

  // voltage code; zero only when no measurable line voltage
  always_comb
  begin
    if (qv_steps > QV_W'(CODE_FULL))
      voltage_code = CODE_FULL;
    else
      voltage_code = qv_steps[4:0];
  end

  // high-current monitor only tells line present or absent
  assign monitor_code = (voltage_code != CODE_NONE) ? CODE_FULL : CODE_NONE;

  // source selection from mode, hook and monitor settings
  always_comb
  begin
    if (offhook)
      src = SRC_CURRENT;
    else if (ctrl.mode || ctrl.onhook_monitor_enable)
      src = SRC_VOLTAGE;
    else
      src = SRC_ZERO;
  end

  always_comb
  begin
    case (src)
      SRC_CURRENT: code_d = current_code;
      SRC_VOLTAGE: code_d = ctrl.mode ? voltage_code : monitor_code;
      SRC_ZERO:    code_d = CODE_NONE;
      default:     code_d = CODE_NONE;
    endcase
  end

  // ==========================================================
  // status field flops
  // one flop per field, each driven by exactly one process; status_q is
  // only their concatenation, so every output bit is still a flop output
  logic [4:0] code_q;
  logic       ovl_q;
  logic       dropout_q;
  logic       protect_q;

  // field order matches the register layout, code on top
  assign status_q = {code_q, ovl_q, dropout_q, protect_q};

  // ==========================================================
  // sense code register
  // the code follows its source one cycle late with no filtering;
  // a host that wants a steady reading must average it itself
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      code_q <= LINE_SENSE_STATUS_RST[CODE_MSB:CODE_LSB];
    end
    else
    begin
      code_q <= code_d;
    end
  end

  // ==========================================================
  // live input overload
  // unlike the sticky copy kept elsewhere, this flag mirrors the masked
  // level and so clears itself one cycle after the excess is gone
  logic ovl_d;

  // billing tone setting deliberately ignored; only the counter masks
  always_comb
  begin
    ovl_d = 1'b0;
    if (rx_level_excess && !offhook_counter_run)
    begin
      ovl_d = 1'b1;
    end
  end

  // registered copy of the masked overload level
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ovl_q <= LINE_SENSE_STATUS_RST[OVL_BIT];
    end
    else
    begin
      ovl_q <= ovl_d;
    end
  end

  // ==========================================================
  // supply dropout
  // hold_q counts the frames still to wait after the supply returns;
  // every new collapse reloads it, so a flickering supply never clears
  // the flag early
  logic [4:0] hold_q;
  logic       hold_last;

  // the frame tick that takes hold_q from one to zero ends the hold
  assign hold_last = dropout_q && line_supply_ok && frame_tick && (hold_q == 5'h01);

  // recovery frame counter; counts frame ticks, so the partial frame
  // in which the supply returns counts as one
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      hold_q <= 5'h00;
    end
    else if (!offhook)
    begin
      hold_q <= 5'h00;
    end
    else if (!line_supply_ok)
    begin
      hold_q <= DROPOUT_HOLD_INIT;
    end
    else if (dropout_q && frame_tick)
    begin
      hold_q <= hold_q - 5'h01;
    end
  end

  // flag: on-hook clears, collapse sets, last hold frame clears
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dropout_q <= LINE_SENSE_STATUS_RST[DROPOUT_BIT];
    end
    else if (!offhook)
    begin
      dropout_q <= 1'b0;
    end
    else if (!line_supply_ok)
    begin
      dropout_q <= 1'b1;
    end
    else if (hold_last)
    begin
      dropout_q <= 1'b0;
    end
  end

  // ==========================================================
  // overload protection indicator
  // a disabled protect path reads as inactive even while the engaged
  // input is high, so a stale sense line cannot show up here
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      protect_q <= LINE_SENSE_STATUS_RST[PROTECT_BIT];
    end
    else
    begin
      protect_q <= protect_engaged && ctrl.overload_protect_enable;
    end
  end

  // ==========================================================
  // secondary-frame read port
  // writes to this address are dropped: every field is read-only, and
  // a write gets no answer at all rather than an error
  logic rd_take;
  logic rd_match;

  assign rd_take  = sec_req.valid && sec_req.read;
  assign rd_match = (sec_req.addr == LINE_SENSE_STATUS_ADDR);

  // answer strobe, one cycle per taken read
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_valid_q <= 1'b0;
    end
    else
    begin
      rd_valid_q <= rd_take;
    end
  end

  // hit marks an answer that came from this register
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_hit_q <= 1'b0;
    end
    else
    begin
      rd_hit_q <= rd_take && rd_match;
    end
  end

  // read data holds until the next read; other addresses read as zero
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_data_q <= 8'h00;
    end
    else if (rd_take && rd_match)
    begin
      rd_data_q <= status_q;
    end
    else if (rd_take)
    begin
      rd_data_q <= 8'h00;
    end
  end

endmodule

// ### common/line_sense_pkg.sv
// constants, field layouts and carrier types for the line sense status register
// assumes one 250 MHz system clock and an external secondary-frame engine
package line_sense_pkg;

  // ==========================================================
  // register map
  localparam logic [4:0] LINE_SENSE_STATUS_ADDR = 5'h13;
  localparam logic [7:0] LINE_SENSE_STATUS_RST  = 8'h00;

  // ==========================================================
  // field positions inside line_sense_status
  localparam int CODE_MSB     = 7;
  localparam int CODE_LSB     = 3;
  localparam int OVL_BIT      = 2;
  localparam int DROPOUT_BIT  = 1;
  localparam int PROTECT_BIT  = 0;

  // ==========================================================
  // sense code scaling and limits
  localparam int          CODE_W          = 5;
  localparam logic [4:0]  CODE_NONE       = 5'h00;
  localparam logic [4:0]  CODE_MAX_NORMAL = 5'h1E;
  localparam logic [4:0]  CODE_FULL       = 5'h1F;
  localparam int          MA_PER_COUNT    = 3;    // loop current step, mA
  localparam int          QV_PER_COUNT    = 11;   // 2.75 V step in quarter volts
  localparam int          OVL_MA_NORMAL   = 140;  // overload threshold, mA
  localparam int          OVL_MA_EURO     = 54;   // overload threshold, mA, euro mode

  // ==========================================================
  // timing
  localparam int          DROPOUT_HOLD_FRAMES = 16;
  localparam logic [4:0]  DROPOUT_HOLD_INIT   = 5'h10;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [4:0] code;
    logic       input_overload_live;
    logic       dropout;
    logic       protect;
  } status_type;

  typedef struct packed {
    logic       valid;
    logic       read;
    logic [4:0] addr;
  } sec_req_type;

  typedef struct packed {
    logic       mode;
    logic       offhook_request;
    logic       onhook_monitor_enable;
    logic       european_termination_mode;
    logic       overload_protect_enable;
  } ctrl_type;

  typedef enum logic [2:0] {
    SRC_ZERO    = 3'b001,
    SRC_VOLTAGE = 3'b010,
    SRC_CURRENT = 3'b100
  } src_type;

endpackage

// ### dv/line_sense_host.sv
// host model: issues secondary-frame reads and writes to the status block
// assumes the bench calls xfer and the block answers on rd_valid_q
`timescale 1ns/1ns
module line_sense_host
  import line_sense_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rd_valid_q,
  input  wire logic       rd_hit_q,
  input  wire logic [7:0] rd_data_q,
  output sec_req_type     sec_req
);
  // ==========
  // one request per frame, dropped on the same edge that takes it
  initial sec_req = '0;
  task automatic xfer(input logic rw, input logic [4:0] a, output logic [7:0] d,
                      output logic h, output logic ok);
    int n;
    @(posedge clk_sys);
    sec_req <= '{1'b1, rw, a};
    @(posedge clk_sys);
    sec_req <= '0;
    ok = 1'b0;
    // bounded: a refused write never answers; look just after each edge
    for (n = 0; n < 4 && !ok; n++)
    begin
      #1 ok = rd_valid_q;
      if (!ok)
        @(posedge clk_sys);
    end
    d = rd_data_q;
    h = rd_hit_q;
  endtask
endmodule

// ### dv/line_sense_status_assertions.sv
// port checker for the line sense status register
// assumes one clock domain; bound into every line_sense_status
`timescale 1ns/1ns
module line_sense_status_assertions
  import line_sense_pkg::*;
#(
  parameter int MA_W = 8
)
(
  input wire logic            clk_sys,
  input wire logic            arst_n,
  input wire logic            frame_tick,
  input wire ctrl_type        ctrl,
  input wire logic [MA_W-1:0] loop_current_ma,
  input wire logic            rx_level_excess,
  input wire logic            offhook_counter_run,
  input wire logic            line_supply_ok,
  input wire logic            protect_engaged,
  input wire sec_req_type     sec_req,
  input wire logic            rd_valid_q,
  input wire logic            rd_hit_q,
  input wire logic [7:0]      rd_data_q,
  input wire status_type      status_q
);
  // ==========
  // single domain, so clock and reset are given once
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  property p_ovl_set; rx_level_excess && !offhook_counter_run |=> status_q.input_overload_live; endproperty
  a_ovl_set: assert property (p_ovl_set) else $error("ovl missing");
  property p_ovl_clr; !rx_level_excess || offhook_counter_run |=> !status_q.input_overload_live; endproperty
  a_ovl_clr: assert property (p_ovl_clr) else $error("ovl stuck");
  property p_drop_set;
    !ctrl.mode && ctrl.offhook_request && !line_supply_ok |=> status_q.dropout;
  endproperty
  a_drop_set: assert property (p_drop_set) else $error("dropout missing");
  property p_drop_hold;
    status_q.dropout && !ctrl.mode && ctrl.offhook_request && !frame_tick |=> status_q.dropout;
  endproperty
  a_drop_hold: assert property (p_drop_hold) else $error("dropout early");
  property p_drop_on; ctrl.mode || !ctrl.offhook_request |=> !status_q.dropout; endproperty
  a_drop_on: assert property (p_drop_on) else $error("dropout on-hook");
  property p_prot;
    1'b1 |=> status_q.protect == $past(protect_engaged && ctrl.overload_protect_enable);
  endproperty
  a_prot: assert property (p_prot) else $error("protect wrong");
  property p_code_ovl;
    !ctrl.mode && ctrl.offhook_request && loop_current_ma >
      (ctrl.european_termination_mode ? 8'h36 : 8'h8C) |=> status_q.code == CODE_FULL;
  endproperty
  a_code_ovl: assert property (p_code_ovl) else $error("overload code");
  property p_code_zero;
    !ctrl.mode && !ctrl.offhook_request && !ctrl.onhook_monitor_enable
      |=> status_q.code == CODE_NONE;
  endproperty
  a_code_zero: assert property (p_code_zero) else $error("code not zero");
  property p_rd_hit;
    sec_req.valid && sec_req.read && sec_req.addr == LINE_SENSE_STATUS_ADDR
      |=> rd_valid_q && rd_hit_q && rd_data_q == $past(status_q);
  endproperty
  a_rd_hit: assert property (p_rd_hit) else $error("read answer");
  property p_no_rd; !(sec_req.valid && sec_req.read) |=> !rd_valid_q; endproperty
  a_no_rd: assert property (p_no_rd) else $error("spurious answer");
  c_hit: cover property (sec_req.valid && sec_req.read ##1 rd_hit_q);
  c_drop: cover property ($rose(status_q.dropout));
  c_ovl: cover property ($fell(status_q.input_overload_live));
endmodule
bind line_sense_status line_sense_status_assertions #(.MA_W(MA_W)) chk_u (.*);

// ### dv/tb_top.sv
// self-checking bench for the line sense status register
// assumes the host model drives sec_req; all inputs launched on rising edges
`timescale 1ns/1ns
module tb_top
  import line_sense_pkg::*;
;
  typedef struct packed
  {
    ctrl_type c; logic [7:0] ma; logic [8:0] qv; logic [4:0] code;
  } row_type;
  logic        clk_sys, arst_n, frame_tick, billing_tone_enable, rx_level_excess;
  logic        offhook_counter_run, line_supply_ok, protect_engaged, rd_valid_q, rd_hit_q;
  logic [7:0]  loop_current_ma, rd_data_q;
  logic [8:0]  line_voltage_qv;
  ctrl_type    ctrl;
  sec_req_type sec_req;
  status_type  status_q;
  int          mismatches = 0;
  int          compares = 0;
  // ==========
  // code table: boundaries of each scale and source
  row_type rows [13] = '{
    '{5'h08, 8'h00, 9'h000, 5'h00}, '{5'h08, 8'h03, 9'h000, 5'h01},
    '{5'h08, 8'h5A, 9'h000, 5'h1E}, '{5'h08, 8'h8C, 9'h000, 5'h1E},
    '{5'h08, 8'h8D, 9'h000, 5'h1F}, '{5'h0A, 8'h36, 9'h000, 5'h12},
    '{5'h0A, 8'h37, 9'h000, 5'h1F}, '{5'h10, 8'h00, 9'h00B, 5'h01},
    '{5'h10, 8'h00, 9'h155, 5'h1F}, '{5'h10, 8'h00, 9'h000, 5'h00},
    '{5'h04, 8'h00, 9'h014, 5'h1F}, '{5'h04, 8'h00, 9'h005, 5'h00},
    '{5'h00, 8'h00, 9'h014, 5'h00}};
  line_sense_status dut_u (.*);
  line_sense_host host_u (.*);
  always #2 clk_sys = ~clk_sys;
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    if (mismatches == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // read through the host; a missing answer ends the run
  task automatic rd(input logic [4:0] a, input logic [8:0] exp);
    logic [7:0] d;
    logic       h, ok;
    host_u.xfer(1'b1, a, d, h, ok);
    if (!ok)
    begin
      mismatches++;
      conclude();
    end
    chk({h, d}, exp);
  endtask
  task automatic settle(input logic [7:0] exp);
    repeat (2) @(posedge clk_sys);
    #1 chk({1'b0, status_q}, {1'b0, exp});
  endtask
  // one frame tick every other cycle
  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge clk_sys) frame_tick <= 1'b1;
      @(posedge clk_sys) frame_tick <= 1'b0;
    end
  endtask
  initial
  begin
    logic [7:0] d;
    logic       h, ok;
    {clk_sys, arst_n, frame_tick, billing_tone_enable, rx_level_excess} = '0;
    {offhook_counter_run, protect_engaged, ctrl, loop_current_ma, line_voltage_qv} = '0;
    line_supply_ok = 1'b1;
    repeat (6) @(posedge clk_sys);
    chk({1'b0, status_q}, 9'h000);
    arst_n <= 1'b1;
    rd(LINE_SENSE_STATUS_ADDR, 9'h100);
    foreach (rows[i])
    begin
      @(posedge clk_sys) ctrl <= rows[i].c;
      {loop_current_ma, line_voltage_qv} <= {rows[i].ma, rows[i].qv};
      repeat (2) @(posedge clk_sys);
      #1 chk({1'b0, status_q}, {1'b0, rows[i].code, 3'h0});
      rd(LINE_SENSE_STATUS_ADDR, {1'b1, rows[i].code, 3'b000});
    end
    // flags together, billing tone on to show it is ignored
    @(posedge clk_sys) {ctrl, loop_current_ma} <= {5'h09, 8'h00};
    {protect_engaged, rx_level_excess, billing_tone_enable, line_supply_ok} <= 4'hE;
    settle(8'h07);
    @(posedge clk_sys) {offhook_counter_run, line_supply_ok, protect_engaged} <= 3'h6;
    tick(15);
    settle(8'h02);
    tick(1);
    #1 chk({1'b0, status_q}, 9'h000);
    @(posedge clk_sys) {ctrl, line_supply_ok, offhook_counter_run} <= '0;
    settle(8'h04);
    // forced on-hook: mode with request set, supply still absent
    @(posedge clk_sys) ctrl <= 5'h18;
    settle(8'h0C);
    @(posedge clk_sys) {ctrl, rx_level_excess} <= '0;
    settle(8'h00);
    host_u.xfer(1'b0, LINE_SENSE_STATUS_ADDR, d, h, ok);
    chk({8'h00, ok}, 9'h000);
    rd(5'h12, 9'h000);
    conclude();
  end
endmodule
